//--- sfu_uart.v
// Serial frame UART with an AHB-Lite register slave and a 16-word transmit FIFO.
// Assumes a single AHB master, word transfers, and pins outside the mclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "sfu_map.vh"

module sfu_uart (
	input  wire        mclk,
	input  wire        resetn,
	input  wire        ce,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [31:0] hrdata,
	input  wire        rxd_in,
	output reg         txd_out,
	input  wire        xck_in,
	output reg         xck_out,
	output reg         xck_oe,
	output reg         irq_rxc,
	output reg         irq_txc,
	output reg         irq_udre
);

	// ----------------------------------------
	// Frame size decode
	// ----------------------------------------
	function [8:0] sfu_mask;
		input [2:0] cs;
		begin
			case (cs)
				3'h0: sfu_mask = 9'h01f;
				3'h1: sfu_mask = 9'h03f;
				3'h2: sfu_mask = 9'h07f;
				3'h7: sfu_mask = 9'h1ff;
				default: sfu_mask = 9'h0ff;
			endcase
		end
	endfunction

	function [3:0] sfu_last;
		input [2:0] cs;
		begin
			case (cs)
				3'h0: sfu_last = 4'h4;
				3'h1: sfu_last = 4'h5;
				3'h2: sfu_last = 4'h6;
				3'h7: sfu_last = 4'h8;
				default: sfu_last = 4'h7;
			endcase
		end
	endfunction

	localparam [2:0] T_IDLE = 3'h0, T_DATA = 3'h1, T_PAR = 3'h2, T_STOP1 = 3'h3, T_STOP2 = 3'h4;
	localparam [2:0] R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h2, R_PAR = 3'h3, R_STOP = 3'h4;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	reg        rx_en_r, tx_en_r, cs2_r, rxc_ie_r, txc_ie_r, udre_ie_r;
	reg [1:0]  mode_r, par_r, cs_lo_r;
	reg        stop2_r, u2x_r, mpcm_r, pwr_off_r;
	reg [11:0] baud_r, bcnt_r;
	reg        rxc_r, txc_r, fe_r, pe_r, dor_r;
	reg [8:0]  rx_buf_r;
	reg [7:0]  a_off_r;
	reg        a_wr_r, a_ok_r;
	reg        rxd_s1_r, rxd_s2_r, xck_s1_r, xck_s2_r, xck_d_r;
	reg [1:0]  rx_h_r;
	reg [2:0]  tx_st_r, rx_st_r;
	reg [8:0]  tx_sh_r, rx_sh_r;
	reg [3:0]  tx_cnt_r, rx_cnt_r, tx_os_r, rx_os_r;
	reg        tx_par_r, tx_end_r, rx_pe_r;
	reg [31:0] rd_mux;

	wire [2:0] cs     = {cs2_r, cs_lo_r};
	wire [8:0] mask   = sfu_mask(cs);
	wire [3:0] last   = sfu_last(cs);
	wire       par_en  = par_r[`SFU_PAR_EN_B];
	wire       par_odd = par_r[`SFU_PAR_ODD_B];
	wire       sync    = (mode_r != `SFU_MODE_ASYNC);
	wire       master  = (mode_r == `SFU_MODE_SMAST);
	wire [3:0] osmax   = u2x_r ? `SFU_OS_DBL : `SFU_OS_NORM;
	wire [3:0] mid     = u2x_r ? `SFU_MID_DBL : `SFU_MID_NORM;
	wire       tx_hold = pwr_off_r | ~tx_en_r;
	wire       rx_hold = pwr_off_r | ~rx_en_r;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire [7:0] a_off   = {haddr[7:2], 2'h0};
	wire       a_take  = hsel & htrans[1] & hready;
	wire       rd_data = a_take & ~hwrite & (a_off == `SFU_OFF_DATA);
	wire       f_s_ready, f_m_valid;
	wire [8:0] f_m_data;
	// Data writes wait here while the FIFO is full
	wire       wr_go   = a_wr_r & ((a_off_r != `SFU_OFF_DATA) | f_s_ready);
	wire       wr_do   = wr_go & a_ok_r;
	wire       push    = wr_do & (a_off_r == `SFU_OFF_DATA);
	wire       udre    = f_s_ready;

	always @* begin
		rd_mux = 32'h0;
		case (a_off)
			`SFU_OFF_DATA:  rd_mux = {23'h0, rx_buf_r};
			`SFU_OFF_STAT:  rd_mux = {24'h0, mpcm_r, u2x_r, pe_r, dor_r, fe_r, udre, txc_r, rxc_r};
			`SFU_OFF_CTRLB: rd_mux = {26'h0, udre_ie_r, txc_ie_r, rxc_ie_r, cs2_r, tx_en_r, rx_en_r};
			`SFU_OFF_CTRLC: rd_mux = {25'h0, cs_lo_r, stop2_r, par_r, mode_r};
			`SFU_OFF_BAUD:  rd_mux = {20'h0, baud_r};
			`SFU_OFF_PWR:   rd_mux = {31'h0, pwr_off_r};
			default:        rd_mux = 32'h0;
		endcase
	end

	always @(posedge mclk) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0;
			a_off_r   <= 8'h0;
			a_wr_r    <= 1'b0;
			a_ok_r    <= 1'b0;
		end else if (ce) begin
			if (a_take) begin
				a_off_r   <= a_off;
				a_wr_r    <= hwrite;
				a_ok_r    <= (hsize == 3'h2);
				hreadyout <= ~hwrite;
				if (!hwrite)
					hrdata <= rd_mux;
			end else if (wr_go) begin
				a_wr_r    <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!resetn) begin
			{rx_en_r, tx_en_r, cs2_r, rxc_ie_r, txc_ie_r, udre_ie_r} <= 6'h0;
			mode_r    <= `SFU_MODE_ASYNC;
			par_r     <= 2'h0;
			stop2_r   <= 1'b0;
			cs_lo_r   <= `SFU_CS_LO_RST;
			u2x_r     <= 1'b0;
			mpcm_r    <= 1'b0;
			baud_r    <= `SFU_BAUD_RST;
			pwr_off_r <= `SFU_PWR_RST;
		end else if (ce && wr_do) begin
			case (a_off_r)
				`SFU_OFF_CTRLB: begin
					rx_en_r   <= hwdata[`SFU_CB_RXEN];
					tx_en_r   <= hwdata[`SFU_CB_TXEN];
					cs2_r     <= hwdata[`SFU_CB_CS2];
					rxc_ie_r  <= hwdata[`SFU_CB_RXCIE];
					txc_ie_r  <= hwdata[`SFU_CB_TXCIE];
					udre_ie_r <= hwdata[`SFU_CB_UDRIE];
				end
				`SFU_OFF_CTRLC: begin
					mode_r  <= hwdata[`SFU_CC_MODE_LO+1:`SFU_CC_MODE_LO];
					par_r   <= hwdata[`SFU_CC_PAR_LO+1:`SFU_CC_PAR_LO];
					stop2_r <= hwdata[`SFU_CC_STOP];
					cs_lo_r <= hwdata[`SFU_CC_CS_LO+1:`SFU_CC_CS_LO];
				end
				`SFU_OFF_STAT: begin
					u2x_r  <= hwdata[`SFU_ST_U2X];
					mpcm_r <= hwdata[`SFU_ST_MPCM];
				end
				`SFU_OFF_BAUD: baud_r    <= hwdata[11:0];
				`SFU_OFF_PWR:  pwr_off_r <= hwdata[0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Pin synchronisers and bit timing
	// ----------------------------------------
	wire tick    = (bcnt_r == 12'h000);
	wire xk_rise = master ? (tick & ~xck_out) : (xck_s2_r & ~xck_d_r);
	wire xk_fall = master ? (tick & xck_out) : (~xck_s2_r & xck_d_r);

	always @(posedge mclk) begin
		if (!resetn) begin
			{rxd_s1_r, rxd_s2_r} <= 2'h3;
			{xck_s1_r, xck_s2_r, xck_d_r} <= 3'h0;
			rx_h_r  <= 2'h3;
			bcnt_r  <= 12'h000;
			tx_os_r <= 4'h0;
			xck_out <= 1'b0;
			xck_oe  <= 1'b0;
		end else if (ce) begin
			rxd_s1_r <= rxd_in;
			rxd_s2_r <= rxd_s1_r;
			xck_s1_r <= xck_in;
			xck_s2_r <= xck_s1_r;
			xck_d_r  <= xck_s2_r;
			xck_oe   <= master & ~pwr_off_r;
			if (pwr_off_r) begin
				bcnt_r  <= baud_r;
				tx_os_r <= 4'h0;
				xck_out <= 1'b0;
			end else begin
				bcnt_r <= tick ? baud_r : bcnt_r - 12'h001;
				if (tick) begin
					rx_h_r  <= {rx_h_r[0], rxd_s2_r};
					tx_os_r <= (tx_os_r == osmax) ? 4'h0 : tx_os_r + 4'h1;
					if (master)
						xck_out <= ~xck_out;
				end
			end
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	wire tx_stb  = ~tx_hold & (sync ? xk_fall : (tick & (tx_os_r == osmax)));
	wire tx_pop  = tx_stb & (tx_st_r == T_IDLE) & f_m_valid;
	wire txc_set = tx_stb & (tx_st_r == T_IDLE) & tx_end_r & ~f_m_valid;

	sfu_fifo #(
		.W  (9),
		.D  (16),
		.AW (4)
	) u_txq (
		.clk     (mclk),
		.resetn  (resetn),
		.ce      (ce),
		.clr     (pwr_off_r),
		.s_valid (push),
		.s_data  (hwdata[8:0]),
		.s_ready (f_s_ready),
		.m_valid (f_m_valid),
		.m_data  (f_m_data),
		.m_ready (tx_pop)
	);

	always @(posedge mclk) begin
		if (!resetn) begin
			tx_st_r  <= T_IDLE;
			txd_out  <= 1'b1;
			tx_sh_r  <= 9'h0;
			tx_cnt_r <= 4'h0;
			tx_par_r <= 1'b0;
			tx_end_r <= 1'b0;
		end else if (ce) begin
			if (tx_hold) begin
				tx_st_r  <= T_IDLE;
				txd_out  <= 1'b1;
				tx_end_r <= 1'b0;
			end else if (tx_stb) begin
				case (tx_st_r)
					T_IDLE: begin
						tx_end_r <= 1'b0;
						if (f_m_valid) begin
							txd_out  <= 1'b0;
							tx_sh_r  <= f_m_data & mask;
							tx_cnt_r <= 4'h0;
							tx_par_r <= (^(f_m_data & mask)) ^ par_odd;
							tx_st_r  <= T_DATA;
						end else
							txd_out <= 1'b1;
					end
					T_DATA: begin
						txd_out  <= tx_sh_r[0];
						tx_sh_r  <= {1'b0, tx_sh_r[8:1]};
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == last)
							tx_st_r <= par_en ? T_PAR : T_STOP1;
					end
					T_PAR: begin
						txd_out <= tx_par_r;
						tx_st_r <= T_STOP1;
					end
					T_STOP1: begin
						txd_out  <= 1'b1;
						tx_end_r <= 1'b1;
						tx_st_r  <= stop2_r ? T_STOP2 : T_IDLE;
					end
					T_STOP2: begin
						txd_out <= 1'b1;
						tx_st_r <= T_IDLE;
					end
					default: tx_st_r <= T_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	// three-sample majority
	wire rx_maj  = (rx_h_r[1] & rx_h_r[0]) | (rx_h_r[1] & rxd_s2_r) | (rx_h_r[0] & rxd_s2_r);
	wire rx_bit  = sync ? rxd_s2_r : rx_maj;
	wire rx_dec  = ~rx_hold & (sync ? xk_rise : (tick & (rx_os_r == mid) & (rx_st_r != R_IDLE)));
	wire mp_ok   = ~mpcm_r | rx_sh_r[last];
	wire rx_done = rx_dec & (rx_st_r == R_STOP) & mp_ok;

	always @(posedge mclk) begin
		if (!resetn) begin
			rx_st_r  <= R_IDLE;
			rx_sh_r  <= 9'h0;
			rx_cnt_r <= 4'h0;
			rx_os_r  <= 4'h0;
			rx_pe_r  <= 1'b0;
		end else if (ce) begin
			if (!sync && tick)
				rx_os_r <= (rx_st_r == R_IDLE || rx_os_r == osmax) ? 4'h0 : rx_os_r + 4'h1;
			if (rx_hold)
				rx_st_r <= R_IDLE;
			else case (rx_st_r)
				R_IDLE: begin
					rx_sh_r  <= 9'h0;
					rx_cnt_r <= 4'h0;
					rx_pe_r  <= 1'b0;
					if (!sync && tick && !rxd_s2_r)
						rx_st_r <= R_START;
					else if (sync && xk_rise && !rxd_s2_r)
						rx_st_r <= R_DATA;
				end
				R_START: begin
					if (rx_dec)
						rx_st_r <= rx_bit ? R_IDLE : R_DATA;
				end
				R_DATA: begin
					if (rx_dec) begin
						rx_sh_r[rx_cnt_r] <= rx_bit;
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == last)
							rx_st_r <= par_en ? R_PAR : R_STOP;
					end
				end
				R_PAR: begin
					if (rx_dec) begin
						rx_pe_r <= rx_bit ^ (^(rx_sh_r & mask)) ^ par_odd;
						rx_st_r <= R_STOP;
					end
				end
				R_STOP: begin
					if (rx_dec)
						rx_st_r <= R_IDLE;
				end
				default: rx_st_r <= R_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Status flags and interrupt requests
	// ----------------------------------------
	wire wr_stat = wr_do & (a_off_r == `SFU_OFF_STAT);
	wire rx_load = rx_done & (~rxc_r | rd_data);

	always @(posedge mclk) begin
		if (!resetn) begin
			rxc_r    <= 1'b0;
			txc_r    <= 1'b0;
			fe_r     <= 1'b0;
			pe_r     <= 1'b0;
			dor_r    <= 1'b0;
			rx_buf_r <= 9'h0;
			irq_rxc  <= 1'b0;
			irq_txc  <= 1'b0;
			irq_udre <= 1'b0;
		end else if (ce) begin
			// Set wins over the read clear
			if (rx_load) begin
				rxc_r    <= 1'b1;
				rx_buf_r <= rx_sh_r & mask;
				fe_r     <= ~rx_bit;
				pe_r     <= rx_pe_r;
			end else if (rd_data)
				rxc_r <= 1'b0;
			if (rx_done && rxc_r && !rd_data)
				dor_r <= 1'b1;
			else if (rd_data)
				dor_r <= 1'b0;
			if (txc_set)
				txc_r <= 1'b1;
			else if (wr_stat && hwdata[`SFU_ST_TXC])
				txc_r <= 1'b0;
			irq_rxc  <= rxc_r & rxc_ie_r;
			irq_txc  <= txc_r & txc_ie_r;
			irq_udre <= udre & udre_ie_r & ~pwr_off_r;
		end
	end

endmodule // sfu_uart

`default_nettype wire

//--- sfu_map.vh
// Address map, field positions, reset values and timing counts for the UART.
// Assumes the includer uses byte offsets on haddr[7:0] and a 32-bit data bus.
`ifndef SFU_MAP_VH
`define SFU_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SFU_OFF_DATA   8'h00
`define SFU_OFF_STAT   8'h04
`define SFU_OFF_CTRLB  8'h08
`define SFU_OFF_CTRLC  8'h0c
`define SFU_OFF_BAUD   8'h10
`define SFU_OFF_PWR    8'h14

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SFU_ST_RXC   0
`define SFU_ST_TXC   1
`define SFU_ST_UDRE  2
`define SFU_ST_FE    3
`define SFU_ST_DOR   4
`define SFU_ST_PE    5
`define SFU_ST_U2X   6
`define SFU_ST_MPCM  7

// ----------------------------------------
// Control B fields
// ----------------------------------------
`define SFU_CB_RXEN   0
`define SFU_CB_TXEN   1
`define SFU_CB_CS2    2
`define SFU_CB_RXCIE  3
`define SFU_CB_TXCIE  4
`define SFU_CB_UDRIE  5

// ----------------------------------------
// Control C fields and encodings
// ----------------------------------------
`define SFU_CC_MODE_LO  0
`define SFU_CC_PAR_LO   2
`define SFU_CC_STOP     4
`define SFU_CC_CS_LO    5
`define SFU_MODE_ASYNC  2'h0
`define SFU_MODE_SMAST  2'h1
`define SFU_PAR_ODD_B   0
`define SFU_PAR_EN_B    1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SFU_CS_LO_RST  2'h3
`define SFU_BAUD_RST   12'h000
`define SFU_PWR_RST    1'h0

// ----------------------------------------
// Oversampling counts
// ----------------------------------------
`define SFU_OS_NORM   4'hf
`define SFU_OS_DBL    4'h7
`define SFU_MID_NORM  4'h9
`define SFU_MID_DBL   4'h5

`endif

//--- sfu_fifo.v
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; clr flushes the contents in one cycle.
`timescale 1ns/1ps
`default_nettype none

module sfu_fifo #(
	parameter W  = 9,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          clk,
	input  wire          resetn,
	input  wire          ce,
	input  wire          clr,
	input  wire          s_valid,
	input  wire [W-1:0]  s_data,
	output wire          s_ready,
	output wire          m_valid,
	output wire [W-1:0]  m_data,
	input  wire          m_ready
);

	localparam [AW:0] FULL = D[AW:0];

	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0]   cnt_r;

	wire push = s_valid & s_ready;
	wire pop  = m_valid & m_ready;

	assign s_ready = (cnt_r != FULL);
	assign m_valid = (cnt_r != {(AW+1){1'b0}});
	assign m_data  = mem[rd_r];

	always @(posedge clk) begin
		if (!resetn || (ce && clr)) begin
			wr_r  <= {AW{1'b0}};
			rd_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (push) begin
				mem[wr_r] <= s_data;
				wr_r      <= wr_r + 1'b1;
			end
			if (pop)
				rd_r <= rd_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

endmodule // sfu_fifo

`default_nettype wire

//--- sfu_uart_props.sv
// Port-level checker for the serial frame UART.
// Assumes one AHB master and a bit time of 8 mclk cycles (BAUD 0, u2x set).
`timescale 1ns/1ps
`default_nettype none

module sfu_uart_props (
	input wire        mclk,
	input wire        resetn,
	input wire        ce,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	input wire        txd_out
);
	wire take    = ce && hsel && htrans[1] && hready;
	wire rd_take = take && !hwrite;
	wire wr_take = take && hwrite;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	hresp_okay_a: assert property (!hresp)
		else $error("hresp not OKAY");
	read_no_wait_a: assert property (rd_take |=> hreadyout)
		else $error("read inserted a wait state");
	write_wait_a: assert property (wr_take |=> !hreadyout)
		else $error("write without wait state");
	reg_write_once_a: assert property (wr_take && haddr[7:2] != 6'h00 |=> !hreadyout ##1 hreadyout)
		else $error("register write wait not one cycle");
	// Data phase only of a read may move hrdata
	rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
		else $error("hrdata moved without a read");
	unmapped_zero_a: assert property (rd_take && haddr[7:2] > 6'h05 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	status_upper_a: assert property (rd_take && haddr[7:2] == 6'h01 |=> hrdata[31:8] == 24'h0)
		else $error("status upper bits set");
	data_upper_a: assert property (rd_take && haddr[7:2] == 6'h00 |=> hrdata[31:9] == 23'h0)
		else $error("data upper bits set");

	// ----------------------------------------
	// Serial line
	// ----------------------------------------
	// Bench never aborts a frame, so every bit lasts 8 cycles
	txd_bit_len_a: assert property ($changed(txd_out) |=> $stable(txd_out) [*7])
		else $error("txd bit shorter than bit time");
endmodule // sfu_uart_props

`default_nettype wire

//--- sfu_line_model.sv
// Remote serial device: sends frames on rxd and decodes frames from txd.
// Assumes asynchronous framing at BT mclk cycles per bit.
`timescale 1ns/1ps
`default_nettype none

module sfu_line_model #(
	parameter int BT = 8
) (
	input  wire logic mclk,
	input  wire logic txd,
	output var  logic rxd
);
	int cyc = 0;

	always @(posedge mclk) begin
		cyc <= cyc + 1;
	end

	initial rxd = 1'b1;

	function automatic logic pbit(input logic [8:0] d, input int n, input int pm);
		logic p;
		p = pm[0];
		for (int i = 0; i < n; i++)
			p ^= d[i];
		return p;
	endfunction

	task automatic put(input logic b);
		rxd <= b;
		repeat (BT) @(posedge mclk);
	endtask

	// start, data LSB first, parity, stops
	task automatic send(input logic [8:0] d, input int n, input int pm,
			input logic fp, input logic s1, input logic s2);
		put(1'b0);
		for (int i = 0; i < n; i++)
			put(d[i]);
		if (pm >= 2)
			put(pbit(d, n, pm) ^ fp);
		put(s1);
		put(s2);
		rxd <= 1'b1;
	endtask

	task automatic glitch(input int n);
		rxd <= 1'b0;
		repeat (n) @(posedge mclk);
		rxd <= 1'b1;
		@(posedge mclk);
	endtask

	// Sample each bit in its middle; t0 stays -1 on timeout
	task automatic get(input int n, input int pm, output logic [8:0] d,
			output logic p, output logic s, output int t0);
		int k;
		d = 9'h000;
		p = 1'b0;
		s = 1'b0;
		t0 = -1;
		for (k = 0; k < 3000 && txd !== 1'b0; k++)
			@(posedge mclk);
		if (txd !== 1'b0)
			return;
		t0 = cyc;
		repeat (BT / 2) @(posedge mclk);
		for (k = 0; k < n; k++) begin
			repeat (BT) @(posedge mclk);
			d[k] = txd;
		end
		if (pm >= 2) begin
			repeat (BT) @(posedge mclk);
			p = txd;
		end
		repeat (BT) @(posedge mclk);
		s = txd;
	endtask
endmodule // sfu_line_model

`default_nettype wire

//--- testbench.sv
// Self-checking bench for the serial frame UART over AHB-Lite.
// Assumes the line model as far side and BAUD 0 with u2x, 8 cycles a bit.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("mismatch %s exp %h got %h", nm, e, a); end end

module testbench;
	logic        mclk = 1'b0;
	logic        resetn, ce, hsel, hwrite, xck_in;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire logic   hready, hreadyout, hresp, rxd_in, txd_out;
	wire logic   xck_out, xck_oe, irq_rxc, irq_txc, irq_udre;
	logic [8:0]  dt, dr, gd, gd2;
	logic        gp, gp2, gs, gs2;
	int          fails = 0, n_checks = 0, t0, t1, k;
	int          nb[5] = '{5, 6, 7, 8, 9};
	int          pv[5] = '{0, 2, 3, 1, 2};
	int          sv[5] = '{0, 1, 0, 1, 0};
	logic [7:0]  ro[6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
	logic [31:0] rv[6] = '{32'h04, 32'h0, 32'h60, 32'h0, 32'h0, 32'h0};
	logic        efp[3] = '{1'b1, 1'b0, 1'b0};
	logic        es1[3] = '{1'b1, 1'b0, 1'b1};
	logic        es2[3] = '{1'b1, 1'b1, 1'b0};
	logic [31:0] est[3] = '{32'h21, 32'h09, 32'h01};

	always #5 mclk = ~mclk;
	assign hready = hreadyout;

	sfu_uart sfu_uart_i (.mclk(mclk), .resetn(resetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_in(rxd_in),
		.txd_out(txd_out), .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe),
		.irq_rxc(irq_rxc), .irq_txc(irq_txc), .irq_udre(irq_udre));
	sfu_line_model #(.BT(8)) sfu_line_model_i (.mclk(mclk), .txd(txd_out), .rxd(rxd_in));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Bounded wait for hready sampled high at an edge
	task automatic wait_rdy;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (hready !== 1'b1 && k < 400);
		if (hready !== 1'b1) begin
			fails++;
			give_verdict;
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic chkrd(input string nm, input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(nm, e, r & m)
	endtask

	task automatic fmt(input int n, input int p, input int s, input logic [7:0] en);
		logic [2:0] c;
		c = (n == 9) ? 3'h7 : 3'(n - 5);
		wr(8'h08, 32'h0);
		wr(8'h0c, {25'h0, c[1:0], s[0], p[1:0], 2'h0});
		wr(8'h08, {24'h0, en | {5'h0, c[2], 2'h0}});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		xck_in = 1'b1;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		foreach (ro[i])
			chkrd("reset value", ro[i], 32'hffffffff, rv[i]);
		wr(8'h18, 32'hffffffff);
		chkrd("unmapped", 8'h18, 32'hffffffff, 32'h0);
		$display("test reset done");

		wr(8'h10, 32'h0);
		wr(8'h04, 32'h40);
		for (int i = 0; i < 5; i++) begin
			fmt(nb[i], pv[i], sv[i], 8'h03);
			dt = 9'h1a5 & 9'((1 << nb[i]) - 1);
			dr = 9'h0d3 & 9'((1 << nb[i]) - 1);
			// Listener armed before the first push, so t0 sees the whole start bit
			fork
				begin
					sfu_line_model_i.get(nb[i], pv[i], gd, gp, gs, t0);
					sfu_line_model_i.get(nb[i], pv[i], gd2, gp2, gs2, t1);
				end
				sfu_line_model_i.send(dr, nb[i], pv[i], 1'b0, 1'b1, 1'b1);
				begin
					wr(8'h00, {23'h0, dt});
					wr(8'h00, {23'h0, dt ^ 9'h001});
				end
			join
			`CHK("tx data", dt, gd)
			`CHK("tx data 2", dt ^ 9'h001, gd2)
			`CHK("tx parity", (pv[i] >= 2) ? sfu_line_model_i.pbit(dt, nb[i], pv[i]) : 1'b0, gp)
			`CHK("tx stop", 1'b1, gs)
			`CHK("tx frame len", (2 + nb[i] + int'(pv[i] >= 2) + sv[i]) * 8, t1 - t0)
			if (t0 < 0 || t1 < 0) begin
				fails++;
				give_verdict;
			end
			chkrd("rx status", 8'h04, 32'h39, 32'h01);
			chkrd("rx data", 8'h00, 32'h1ff, {23'h0, dr});
		end
		$display("test formats done");

		fmt(8, 2, 1, 8'h0b);
		for (int i = 0; i < 3; i++) begin
			sfu_line_model_i.send(9'h05a, 8, 2, efp[i], es1[i], es2[i]);
			`CHK("rx irq", 1'b1, irq_rxc)
			chkrd("err status", 8'h04, 32'h39, est[i]);
			bus(1'b0, 8'h00, 32'h0);
		end
		// Low second stop looks like a start; let that frame pass
		repeat (150) @(posedge mclk);
		bus(1'b0, 8'h00, 32'h0);
		sfu_line_model_i.send(9'h011, 8, 2, 1'b0, 1'b1, 1'b1);
		sfu_line_model_i.send(9'h022, 8, 2, 1'b0, 1'b1, 1'b1);
		chkrd("overrun", 8'h04, 32'h11, 32'h11);
		chkrd("kept data", 8'h00, 32'h1ff, 32'h011);
		sfu_line_model_i.glitch(2);
		// Long enough for a wrongly taken frame to finish
		repeat (150) @(posedge mclk);
		chkrd("false start", 8'h04, 32'h01, 32'h0);
		wr(8'h04, 32'hc0);
		sfu_line_model_i.send(9'h011, 8, 2, 1'b0, 1'b1, 1'b1);
		chkrd("mp drop", 8'h04, 32'h01, 32'h0);
		sfu_line_model_i.send(9'h091, 8, 2, 1'b0, 1'b1, 1'b1);
		chkrd("mp take", 8'h00, 32'h1ff, 32'h091);
		wr(8'h04, 32'h40);
		$display("test receive errors done");

		fmt(8, 0, 0, 8'h00);
		repeat (16) wr(8'h00, 32'h0c3);
		chkrd("fifo full", 8'h04, 32'h04, 32'h0);
		wr(8'h14, 32'h1);
		chkrd("power flush", 8'h04, 32'h04, 32'h04);
		wr(8'h14, 32'h0);
		repeat (16) wr(8'h00, 32'h0c3);
		// Earlier frames left txc set
		wr(8'h04, 32'h42);
		wr(8'h08, 32'h12);
		for (int i = 0; i < 1000; i++) begin
			bus(1'b0, 8'h04, 32'h0);
			if (r[1] === 1'b1)
				break;
		end
		`CHK("txc irq", 1'b1, irq_txc)
		chkrd("drained", 8'h04, 32'h06, 32'h06);
		wr(8'h04, 32'h42);
		chkrd("txc clear", 8'h04, 32'h02, 32'h0);
		`CHK("txc irq off", 1'b0, irq_txc)
		wr(8'h08, 32'h20);
		wr(8'h0c, 32'h61);
		@(posedge mclk);
		`CHK("udre irq", 1'b1, irq_udre)
		`CHK("xck drive", 1'b1, xck_oe)
		gp = xck_out;
		@(posedge mclk);
		`CHK("xck toggle", ~gp, xck_out)
		$display("test fifo and power done");
		give_verdict;
	end
endmodule // testbench

bind sfu_uart sfu_uart_props sfu_uart_props_i (.mclk(mclk), .resetn(resetn), .ce(ce),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd_out(txd_out));

`default_nettype wire
